// ===== hw/perf_event_defines.vh
// Constants for the performance event selection and qualification logic
// Behaviour
// - Code CEH, mask 00H counts each retired packed-integer instruction.
// - Code D4H counts segment rename stalls; mask picks ES, DS, FS, GS, or all.
// - Code D5H counts segment renames with the same per-register mask encoding.
// - Cache-state events: mask bits 3..0 select modified, exclusive, shared, invalid.
// - Cache-state mask FH counts all states; mask 0H never increments.
// - Bus events: mask bit 5 low counts own transactions, high counts any agent.
// - Older-core mode: each counter takes its code from its own field of shared control.
// - Most events count on either counter; code D6H counts only on counter 1.
// - Code 00H counts data reads, split halves separately, excluding translation and I/O reads.
// - Data read and write events may come twice per clock; counter adds two.
// - Code 01H counts data writes, split halves separately, excluding I/O writes.
// - Code 02H counts data translation buffer misses.
// - Code 03H counts data read misses; repeat reads during a burst fill add nothing.
// - Code 04H counts data write misses, excluding translation handling and I/O.
`ifndef PERF_EVENT_DEFINES_VH
`define PERF_EVENT_DEFINES_VH

`define CNT_W            40
`define AW               4
// Register offsets
`define ADDR_SEL0        4'h0
`define ADDR_SEL1        4'h1
`define ADDR_SHARED      4'h2
`define ADDR_MODE        4'h3
`define ADDR_CNT0_LO     4'h4
`define ADDR_CNT0_HI     4'h5
`define ADDR_CNT1_LO     4'h6
`define ADDR_CNT1_HI     4'h7
// Selector fields
`define SEL_CODE         7:0
`define SEL_MASK         15:8
`define SEL_RST          32'h0000_0000
`define SHARED_CODE0     5:0
`define SHARED_CODE1     21:16
`define SHARED_RST       32'h0000_0000
// Newer-core event codes
`define EV_PKD_RET       8'hCE
`define EV_SEG_STALL     8'hD4
`define EV_SEG_REN       8'hD5
`define EV_L2_STATE      8'h2E
`define EV_BUS_TRAN      8'h70
// Older-core event codes
`define EV_DRD           6'h00
`define EV_DWR           6'h01
`define EV_DTLB          6'h02
`define EV_DRD_MISS      6'h03
`define EV_DWR_MISS      6'h04
// Counter-restricted event (counter 1 only)
`define EV_ONLY1         8'hD6
// Mask values, bus-any mask bit index and burst beat limit
`define MSK_NONE         8'h00
`define MSK_SEG_ALL      4'hF
`define MSK_BUS_ANY      5
`define BURST_BEATS      2'h3

`endif

// ===== hw/event_select.v
// Decodes one counter's selection into a 2-bit increment; drd_cnt and dwr_cnt pass through unchanged
`timescale 1ns/1ns
`include "perf_event_defines.vh"
module event_select #(
   parameter CNT_ID = 0
) (
   input  wire       legacy_mode,
   input  wire [7:0] code,
   input  wire [7:0] mask,
   input  wire [5:0] legacy_code,
   input  wire       retired_packed_int_instr,
   input  wire [3:0] segment_rename_stall_event,
   input  wire [3:0] segment_rename_event,
   input  wire [3:0] l2_state_event,
   input  wire       bus_own_event,
   input  wire       bus_other_event,
   input  wire       rename_retired_event,
   input  wire [1:0] drd_cnt,
   input  wire [1:0] dwr_cnt,
   input  wire       dtlb_miss,
   input  wire       drd_miss_new,
   input  wire       dwr_miss,
   output reg  [1:0] inc
);
   wire seg_mask_ok = (mask[7:4] == 4'h0) && ((mask[3:0] == 4'h1) || (mask[3:0] == 4'h2) ||
                      (mask[3:0] == 4'h4) || (mask[3:0] == 4'h8) || (mask[3:0] == `MSK_SEG_ALL));
   always @* begin
      inc = 2'h0;
      if (legacy_mode) begin
         case (legacy_code)
            `EV_DRD:      inc = drd_cnt;
            `EV_DWR:      inc = dwr_cnt;
            `EV_DTLB:     inc = {1'b0, dtlb_miss};
            `EV_DRD_MISS: inc = {1'b0, drd_miss_new};
            `EV_DWR_MISS: inc = {1'b0, dwr_miss};
            default:      inc = 2'h0;
         endcase
      end else begin
         case (code)
            `EV_PKD_RET:
               if (mask == `MSK_NONE) inc = {1'b0, retired_packed_int_instr};
            `EV_SEG_STALL:
               if (seg_mask_ok) inc = {1'b0, |(segment_rename_stall_event & mask[3:0])};
            `EV_SEG_REN:
               if (seg_mask_ok) inc = {1'b0, |(segment_rename_event & mask[3:0])};
            `EV_L2_STATE:
               inc = {1'b0, |(l2_state_event & mask[3:0])};
            `EV_BUS_TRAN:
               inc = {1'b0, bus_own_event | (mask[`MSK_BUS_ANY] & bus_other_event)};
            `EV_ONLY1:
               if (CNT_ID == 1 && mask == `MSK_NONE) inc = {1'b0, rename_retired_event};
            default: inc = 2'h0;
         endcase
      end
   end
endmodule // event_select

// ===== hw/read_miss_filter.v
// Suppresses repeat read-miss counts to a line while its burst fill runs
`timescale 1ns/1ns
`include "perf_event_defines.vh"
module read_miss_filter (
   input  wire       clk,
   input  wire       srst,
   input  wire       drd_miss,
   input  wire       drd_miss_same_line,
   input  wire       burst_ready_n,
   output wire       drd_miss_new
);
   reg       fill_ff;
   reg [1:0] beats_ff;
   reg       burst_ready_n_s1_ff;
   reg       burst_ready_n_s2_ff;
   wire      beat = ~burst_ready_n_s2_ff;
   // Repeat misses to the filling line add nothing until the last beat
   assign drd_miss_new = drd_miss & ~(fill_ff & drd_miss_same_line);
   always @(posedge clk) begin
      if (srst) begin
         burst_ready_n_s1_ff <= 1'b1;
         burst_ready_n_s2_ff <= 1'b1;
         fill_ff    <= 1'b0;
         beats_ff   <= 2'h0;
      end else begin
         burst_ready_n_s1_ff <= burst_ready_n;
         burst_ready_n_s2_ff <= burst_ready_n_s1_ff;
         if (beat) begin
            if (beats_ff == `BURST_BEATS) begin
               fill_ff  <= 1'b0;
               beats_ff <= 2'h0;
            end else begin
               fill_ff  <= 1'b1;
               beats_ff <= beats_ff + 2'h1;
            end
         end
      end
   end
endmodule // read_miss_filter

// ===== hw/perf_event_top.v
// Performance event selectors, counters and register port
`timescale 1ns/1ns
`include "perf_event_defines.vh"
module perf_event_top (
   input  wire        clk,
   input  wire        srst,
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   input  wire        retired_packed_int_instr,
   input  wire [3:0]  segment_rename_stall_event,
   input  wire [3:0]  segment_rename_event,
   input  wire [3:0]  l2_state_event,
   input  wire        bus_own_event,
   input  wire        bus_other_event,
   input  wire        rename_retired_event,
   input  wire [1:0]  drd_cnt,
   input  wire [1:0]  dwr_cnt,
   input  wire        dtlb_miss,
   input  wire        drd_miss,
   input  wire        drd_miss_same_line,
   input  wire        dwr_miss,
   input  wire        burst_ready_n,
   output reg  [39:0] count0,
   output reg  [39:0] count1
);
   reg  [31:0] event_selector_0_ff;
   reg  [31:0] event_selector_1_ff;
   reg  [31:0] shared_counter_control_reg_ff;
   reg         legacy_ff;
   wire [1:0]  inc0;
   wire [1:0]  inc1;
   wire        drd_miss_new;

   read_miss_filter u_filt (
      .clk                (clk),
      .srst               (srst),
      .drd_miss           (drd_miss),
      .drd_miss_same_line (drd_miss_same_line),
      .burst_ready_n      (burst_ready_n),
      .drd_miss_new       (drd_miss_new)
   );

   event_select #(.CNT_ID(0)) u_sel0 (
      .legacy_mode                (legacy_ff),
      .code                       (event_selector_0_ff[`SEL_CODE]),
      .mask                       (event_selector_0_ff[`SEL_MASK]),
      .legacy_code                (shared_counter_control_reg_ff[`SHARED_CODE0]),
      .retired_packed_int_instr   (retired_packed_int_instr),
      .segment_rename_stall_event (segment_rename_stall_event),
      .segment_rename_event       (segment_rename_event),
      .l2_state_event             (l2_state_event),
      .bus_own_event              (bus_own_event),
      .bus_other_event            (bus_other_event),
      .rename_retired_event       (rename_retired_event),
      .drd_cnt                    (drd_cnt),
      .dwr_cnt                    (dwr_cnt),
      .dtlb_miss                  (dtlb_miss),
      .drd_miss_new               (drd_miss_new),
      .dwr_miss                   (dwr_miss),
      .inc                        (inc0)
   );

   event_select #(.CNT_ID(1)) u_sel1 (
      .legacy_mode                (legacy_ff),
      .code                       (event_selector_1_ff[`SEL_CODE]),
      .mask                       (event_selector_1_ff[`SEL_MASK]),
      .legacy_code                (shared_counter_control_reg_ff[`SHARED_CODE1]),
      .retired_packed_int_instr   (retired_packed_int_instr),
      .segment_rename_stall_event (segment_rename_stall_event),
      .segment_rename_event       (segment_rename_event),
      .l2_state_event             (l2_state_event),
      .bus_own_event              (bus_own_event),
      .bus_other_event            (bus_other_event),
      .rename_retired_event       (rename_retired_event),
      .drd_cnt                    (drd_cnt),
      .dwr_cnt                    (dwr_cnt),
      .dtlb_miss                  (dtlb_miss),
      .drd_miss_new               (drd_miss_new),
      .dwr_miss                   (dwr_miss),
      .inc                        (inc1)
   );

   // Software write to a counter word wins over a same-cycle increment
   always @(posedge clk) begin
      if (srst) begin
         event_selector_0_ff           <= `SEL_RST;
         event_selector_1_ff           <= `SEL_RST;
         shared_counter_control_reg_ff <= `SHARED_RST;
         legacy_ff                     <= 1'b0;
         count0                        <= 40'h00_0000_0000;
         count1                        <= 40'h00_0000_0000;
         reg_rdata                     <= 32'h0000_0000;
      end else begin
         count0 <= count0 + {38'h0, inc0};
         count1 <= count1 + {38'h0, inc1};
         if (reg_wr) begin
            case (reg_addr)
               `ADDR_SEL0:    event_selector_0_ff <= reg_wdata;
               `ADDR_SEL1:    event_selector_1_ff <= reg_wdata;
               `ADDR_SHARED:  shared_counter_control_reg_ff <= reg_wdata;
               `ADDR_MODE:    legacy_ff <= reg_wdata[0];
               `ADDR_CNT0_LO: count0[31:0] <= reg_wdata;
               `ADDR_CNT0_HI: count0[39:32] <= reg_wdata[7:0];
               `ADDR_CNT1_LO: count1[31:0] <= reg_wdata;
               `ADDR_CNT1_HI: count1[39:32] <= reg_wdata[7:0];
               default:       legacy_ff <= legacy_ff;
            endcase
         end
         if (reg_rd) begin
            case (reg_addr)
               `ADDR_SEL0:    reg_rdata <= event_selector_0_ff;
               `ADDR_SEL1:    reg_rdata <= event_selector_1_ff;
               `ADDR_SHARED:  reg_rdata <= shared_counter_control_reg_ff;
               `ADDR_MODE:    reg_rdata <= {31'h0, legacy_ff};
               `ADDR_CNT0_LO: reg_rdata <= count0[31:0];
               `ADDR_CNT0_HI: reg_rdata <= {24'h0, count0[39:32]};
               `ADDR_CNT1_LO: reg_rdata <= count1[31:0];
               `ADDR_CNT1_HI: reg_rdata <= {24'h0, count1[39:32]};
               default:       reg_rdata <= 32'h0000_0000;
            endcase
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end
   end
endmodule // perf_event_top

// ===== tb/perf_event_top_assertions.sv
// Port-level checker for the performance event block
`timescale 1ns/1ns
module perf_event_top_assertions (
   input logic        clk,
   input logic        srst,
   input logic [3:0]  reg_addr,
   input logic [31:0] reg_wdata,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [31:0] reg_rdata,
   input logic        retired_packed_int_instr,
   input logic [3:0]  segment_rename_stall_event,
   input logic [3:0]  segment_rename_event,
   input logic [3:0]  l2_state_event,
   input logic        bus_own_event,
   input logic        bus_other_event,
   input logic        rename_retired_event,
   input logic [1:0]  drd_cnt,
   input logic [1:0]  dwr_cnt,
   input logic        dtlb_miss,
   input logic        drd_miss,
   input logic        dwr_miss,
   input logic [39:0] count0,
   input logic [39:0] count1
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_quiet;
      !reg_wr && !(retired_packed_int_instr | bus_own_event | bus_other_event | rename_retired_event | dtlb_miss
         | drd_miss | dwr_miss) && !(|{segment_rename_stall_event, segment_rename_event, l2_state_event, drd_cnt, dwr_cnt});
   endsequence
   sequence s_wr_lo0;
      reg_wr && reg_addr == 4'h4;
   endsequence
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not zero when idle");
   a_reset_clears: assert property ($past(srst) |-> count0 == 40'h0 && count1 == 40'h0) else $error("counter not cleared");
   a_cnt0_step_max: assert property (!$past(reg_wr) && !$past(srst) |-> 40'(count0 - $past(count0)) <= 40'h2)
      else $error("counter 0 stepped by more than two");
   a_cnt1_step_max: assert property (!$past(reg_wr) && !$past(srst) |-> 40'(count1 - $past(count1)) <= 40'h2)
      else $error("counter 1 stepped by more than two");
   a_quiet_hold: assert property (s_quiet |=> $stable(count0) && $stable(count1))
      else $error("counter moved with no event");
   a_cnt0_lo_write: assert property (s_wr_lo0 |=> count0[31:0] == $past(reg_wdata)) else $error("count write lost");
   a_cnt1_hi_write: assert property (reg_wr && reg_addr == 4'h7 |=> count1[39:32] == $past(reg_wdata[7:0]))
      else $error("count high write lost");
   a_unmapped_read: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
   a_cnt0_read: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata == 32'($past(count0)))
      else $error("count read mismatch");
endmodule // perf_event_top_assertions
bind perf_event_top perf_event_top_assertions u_chk (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .retired_packed_int_instr, .segment_rename_stall_event, .segment_rename_event, .l2_state_event, .bus_own_event,
   .bus_other_event, .rename_retired_event, .drd_cnt, .dwr_cnt, .dtlb_miss, .drd_miss, .dwr_miss, .count0, .count1);

// ===== tb/perf_event_top_tb.sv
// Self-checking bench for the performance event block
`timescale 1ns/1ns
`include "perf_event_defines.vh"
module perf_event_top_tb;
   logic        clk, srst, reg_wr, reg_rd, rd_seen, retired_packed_int_instr, bus_own_event, bus_other_event;
   logic        rename_retired_event, dtlb_miss, drd_miss, drd_miss_same_line, dwr_miss, burst_ready_n;
   logic [3:0]  reg_addr, segment_rename_stall_event, segment_rename_event, l2_state_event;
   logic [31:0] reg_wdata, reg_rdata;
   logic [1:0]  drd_cnt, dwr_cnt;
   logic [39:0] count0, count1;
   logic [31:0] exp_q[$];
   logic [15:0] tab[21] = '{16'h00CE, 16'h01CE, 16'h01D4, 16'h02D4, 16'h04D4, 16'h08D4, 16'h0FD4, 16'h03D4, 16'h01D5,
      16'h02D5, 16'h04D5, 16'h08D5, 16'h0FD5, 16'h0F2E, 16'h002E, 16'h052E, 16'h082E, 16'h0070, 16'h2070, 16'h00D6, 16'h0055};
   int          num_errors = 0;
   int          num_checks = 0;
   perf_event_top u_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .retired_packed_int_instr,
      .segment_rename_stall_event, .segment_rename_event, .l2_state_event, .bus_own_event, .bus_other_event,
      .rename_retired_event, .drd_cnt, .dwr_cnt, .dtlb_miss, .drd_miss, .drd_miss_same_line, .dwr_miss,
      .burst_ready_n, .count0, .count1);
   task automatic complete_run;
      if (num_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t read %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a; exp_q.push_back(exp);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // Seg and cache state stimulus kept one-hot or zero so per-cycle sums stay unambiguous
   task automatic drive_ev(input bit rnd);
      int b;
      b = rnd ? $urandom % 3 : 0;
      retired_packed_int_instr <= rnd & $urandom; rename_retired_event <= rnd & $urandom;
      segment_rename_stall_event <= rnd ? 4'h1 << ($urandom % 5) : 4'h0;
      segment_rename_event <= rnd ? 4'h1 << ($urandom % 5) : 4'h0;
      l2_state_event <= rnd ? 4'h1 << ($urandom % 5) : 4'h0;
      bus_own_event <= (b == 1); bus_other_event <= (b == 2);
      drd_cnt <= rnd ? 2'($urandom % 3) : 2'h0; dwr_cnt <= rnd ? 2'($urandom % 3) : 2'h0;
      dtlb_miss <= rnd & $urandom; drd_miss <= rnd & $urandom; dwr_miss <= rnd & $urandom;
   endtask
   function automatic logic [1:0] model(input bit id, input logic [15:0] s, input bit leg, input logic [5:0] lc);
      if (leg)
         case (lc)
            6'h00: return drd_cnt;
            6'h01: return dwr_cnt;
            6'h02: return {1'b0, dtlb_miss};
            6'h03: return {1'b0, drd_miss};
            6'h04: return {1'b0, dwr_miss};
            default: return 2'h0;
         endcase
      case (s[7:0])
         8'hCE: return (s[15:8] == 8'h00) ? {1'b0, retired_packed_int_instr} : 2'h0;
         8'hD4: return (s[15:8] inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h0F}) ? 2'(|(segment_rename_stall_event & s[11:8])) : 2'h0;
         8'hD5: return (s[15:8] inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h0F}) ? 2'(|(segment_rename_event & s[11:8])) : 2'h0;
         8'h2E: return 2'(|(l2_state_event & s[11:8]));
         8'h70: return 2'(bus_own_event | (s[13] & bus_other_event));
         8'hD6: return 2'(id & rename_retired_event);
         default: return 2'h0;
      endcase
   endfunction
   task automatic setup(input bit leg, input logic [15:0] s0, s1, input logic [5:0] l0, l1);
      wr(`ADDR_MODE, {31'h0, leg});
      wr(`ADDR_SEL0, {16'h0, s0});
      wr(`ADDR_SEL1, {16'h0, s1});
      wr(`ADDR_SHARED, {10'h0, l1, 10'h0, l0});
      rd(`ADDR_SHARED, {10'h0, l1, 10'h0, l0});
      for (int a = 4; a < 8; a++) wr(4'(a), 32'h0);
   endtask
   task automatic run(input bit leg, input logic [15:0] s0, s1, input logic [5:0] l0, l1);
      logic [31:0] e0, e1;
      e0 = 0;
      e1 = 0;
      setup(leg, s0, s1, l0, l1);
      repeat (20) begin
         @(posedge clk);
         drive_ev(1);
         @(negedge clk);
         e0 += model(0, s0, leg, l0);
         e1 += model(1, s1, leg, l1);
      end
      @(posedge clk);
      drive_ev(0);
      rd(`ADDR_CNT0_LO, e0);
      rd(`ADDR_CNT1_LO, e1);
   endtask
   always @(posedge clk) rd_seen <= reg_rd;
   always @(negedge clk) if (rd_seen) check(reg_rdata, exp_q.pop_front());
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      complete_run();
   end
   initial begin
      void'($urandom(90));
      srst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; drd_miss_same_line = 0; burst_ready_n = 1;
      drive_ev(0);
      repeat (8) @(posedge clk);
      srst <= 0;
      for (int a = 0; a < 8; a++) rd(4'(a), 32'h0);
      rd(4'h9, 32'h0);
      // High counter words are only eight bits wide
      wr(`ADDR_CNT1_HI, 32'hFFFF_FFA5);
      rd(`ADDR_CNT1_HI, 32'h0000_00A5);
      wr(`ADDR_CNT0_HI, 32'h0000_005A);
      rd(`ADDR_CNT0_HI, 32'h0000_005A);
      for (int i = 0; i < 21; i++) run(0, tab[i], tab[(i + 1) % 21], 6'h00, 6'h00);
      for (int l = 0; l < 6; l++) run(1, 16'h00CE, 16'h00CE, (l == 5) ? 6'h3F : 6'(l), 6'((l + 1) % 5));
      setup(1, 16'h0, 16'h0, 6'h03, 6'h03);
      @(posedge clk);
      drd_miss <= 1;
      @(posedge clk);
      drd_miss <= 0; burst_ready_n <= 0;
      @(posedge clk);
      burst_ready_n <= 1;
      repeat (4) @(posedge clk);
      drd_miss <= 1; drd_miss_same_line <= 1;
      @(posedge clk);
      drd_miss <= 0; drd_miss_same_line <= 0;
      rd(`ADDR_CNT0_LO, 32'h1);
      rd(`ADDR_CNT0_HI, 32'h0);
      rd(`ADDR_CNT1_LO, 32'h1);
      rd(`ADDR_CNT1_HI, 32'h0);
      repeat (3) @(posedge clk);
      complete_run();
   end
endmodule // perf_event_top_tb
